// file: rtl/fpc_flash_program_control.sv
// Chosen here: the Wishbone slave port and the placing of the registers.
module fpc_flash_program_control (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic por_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [3:0] flash_op,
   output logic flash_go,
   input wire logic flash_done,
   input wire logic flash_fail,
   input wire logic flash_low_volt,
   output logic bank_swap,
   output logic lower_bank_is_2,
   output logic irq
);
   logic start_reg, start_next;
   logic wen_reg, wen_next;
   logic opfail_reg, opfail_next;
   logic lvfail_reg, lvfail_next;
   logic swap_reg, swap_next;
   logic [3:0] op_reg, op_next;
   logic go_reg, go_next;
   fpc_pkg::fpc_lock_t lock_reg, lock_next;
   logic [2:0] stat_reg, stat_next;
   logic [2:0] mask_reg, mask_next;
   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic req, wr, unlocked;
   logic [31:0] ctrl_view;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
      hit = (a == o);
   endfunction

   assign req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wr = req && wb_we_i;
   assign unlocked = (lock_reg == fpc_pkg::FPC_LK_OPEN);

   always_comb begin
      ctrl_view = 32'h00000000;
      ctrl_view[fpc_pkg::BIT_START] = start_reg;
      ctrl_view[fpc_pkg::BIT_WEN] = wen_reg;
      ctrl_view[fpc_pkg::BIT_OPFAIL] = opfail_reg;
      ctrl_view[fpc_pkg::BIT_LVFAIL] = lvfail_reg;
      ctrl_view[fpc_pkg::BIT_SWAP] = swap_reg;
      ctrl_view[fpc_pkg::OP_LSB +: fpc_pkg::OP_W] = op_reg;
   end

   // Power-on domain: start, enable, error flags
   always_comb begin
      start_next = start_reg;
      wen_next = wen_reg;
      opfail_next = opfail_reg;
      lvfail_next = lvfail_reg;
      go_next = 1'b0;
      if (start_reg && flash_done) begin
         start_next = 1'b0;
      end
      if (start_reg && flash_fail) begin
         opfail_next = 1'b1;
      end
      if (start_reg && flash_low_volt) begin
         lvfail_next = 1'b1;
      end
      if (wr && hit(wb_adr_i, fpc_pkg::ADDR_CTRL) && wb_sel_i[1]) begin
         if (!start_reg) begin
            wen_next = wb_dat_i[fpc_pkg::BIT_WEN];
         end
         // Clearing is ignored; set needs enable and unlock
         if (wb_dat_i[fpc_pkg::BIT_START] && wen_reg && unlocked
             && !start_reg) begin
            start_next = 1'b1;
            go_next = 1'b1;
            if (op_reg == fpc_pkg::OP_CLEAR_ERR) begin
               opfail_next = 1'b0;
               lvfail_next = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!por_n) begin
         start_reg <= 1'b0;
         wen_reg <= 1'b0;
         opfail_reg <= 1'b0;
         lvfail_reg <= 1'b0;
         go_reg <= 1'b0;
      end else begin
         start_reg <= start_next;
         wen_reg <= wen_next;
         opfail_reg <= opfail_next;
         lvfail_reg <= lvfail_next;
         go_reg <= go_next;
      end
   end

   // System reset domain: op code, swap, lock, interrupts, bus
   always_comb begin
      op_next = op_reg;
      swap_next = swap_reg;
      lock_next = lock_reg;
      mask_next = mask_reg;
      stat_next = stat_reg;
      ack_next = req;
      rdat_next = 32'h00000000;
      if (req) begin
         // Any access other than the completing one closes the lock
         lock_next = fpc_pkg::FPC_LK_IDLE;
      end
      if (wr && hit(wb_adr_i, fpc_pkg::ADDR_KEY)
          && (wb_sel_i == 4'hF)) begin
         if (wb_dat_i == fpc_pkg::KEY_FIRST) begin
            lock_next = fpc_pkg::FPC_LK_KEY1;
         end else if (wb_dat_i == fpc_pkg::KEY_SECOND
                      && lock_reg == fpc_pkg::FPC_LK_KEY1) begin
            lock_next = fpc_pkg::FPC_LK_OPEN;
         end
      end
      if (wr && hit(wb_adr_i, fpc_pkg::ADDR_CTRL)) begin
         if (wb_sel_i[0] && !wen_reg && !start_reg) begin
            op_next = wb_dat_i[fpc_pkg::OP_LSB +: fpc_pkg::OP_W];
         end
         if (wb_sel_i[0] && !wen_reg && unlocked) begin
            swap_next = wb_dat_i[fpc_pkg::BIT_SWAP];
         end
      end
      if (wr && hit(wb_adr_i, fpc_pkg::ADDR_IRQ_MASK) && wb_sel_i[0]) begin
         mask_next = wb_dat_i[2:0];
      end
      if (wr && hit(wb_adr_i, fpc_pkg::ADDR_IRQ_STAT) && wb_sel_i[0]) begin
         stat_next = stat_reg & ~wb_dat_i[2:0];
      end
      // Hardware set wins over a same-cycle clear
      if (start_reg && flash_done) begin
         stat_next[fpc_pkg::IRQ_DONE] = 1'b1;
      end
      if (start_reg && flash_fail) begin
         stat_next[fpc_pkg::IRQ_OPFAIL] = 1'b1;
      end
      if (start_reg && flash_low_volt) begin
         stat_next[fpc_pkg::IRQ_LVFAIL] = 1'b1;
      end
      if (req && !wb_we_i) begin
         case (wb_adr_i)
            fpc_pkg::ADDR_CTRL: rdat_next = ctrl_view;
            fpc_pkg::ADDR_IRQ_STAT: rdat_next = {29'h0, stat_reg};
            fpc_pkg::ADDR_IRQ_MASK: rdat_next = {29'h0, mask_reg};
            default: rdat_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         op_reg <= 4'h0;
         swap_reg <= 1'b0;
         lock_reg <= fpc_pkg::FPC_LK_IDLE;
         mask_reg <= 3'h0;
         stat_reg <= 3'h0;
         ack_reg <= 1'b0;
         rdat_reg <= 32'h00000000;
      end else begin
         op_reg <= op_next;
         swap_reg <= swap_next;
         lock_reg <= lock_next;
         mask_reg <= mask_next;
         stat_reg <= stat_next;
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;
   assign flash_op = op_reg;
   assign flash_go = go_reg;
   assign bank_swap = swap_reg;
   assign lower_bank_is_2 = swap_reg;
   assign irq = |(stat_reg & mask_reg);

   // Start and launch guards
   a_start_needs_unlock: assert property (@(posedge mclk) disable iff (!por_n)
      $rose(start_reg) |-> $past(wen_reg) && $past(unlocked))
      else $error("start set without enable and unlock");

   a_start_no_sw_clear: assert property (@(posedge mclk) disable iff (!por_n)
      $fell(start_reg) |-> $past(flash_done))
      else $error("start cleared without completion");

   a_go_with_start: assert property (@(posedge mclk) disable iff (!por_n)
      $rose(start_reg) |-> flash_go ##1 !flash_go)
      else $error("launch pulse wrong");

   a_go_needs_start: assert property (@(posedge mclk) disable iff (!por_n)
      flash_go |-> start_reg)
      else $error("launch pulse while idle");

   a_done_clears_start: assert property (@(posedge mclk)
      disable iff (!por_n)
      start_reg && flash_done |=> !start_reg)
      else $error("start not cleared at completion");

   // Field locks
   a_op_locked: assert property (@(posedge mclk)
      disable iff (!nrst || !por_n)
      $past(wen_reg) |-> $stable(op_reg))
      else $error("op code changed while enabled");

   a_op_busy_stable: assert property (@(posedge mclk)
      disable iff (!nrst || !por_n)
      $past(start_reg) |-> $stable(op_reg))
      else $error("op code changed while busy");

   a_wen_busy_stable: assert property (@(posedge mclk)
      disable iff (!por_n)
      $past(start_reg) |-> $stable(wen_reg))
      else $error("enable changed while busy");

   // Error flags
   a_opfail_clear: assert property (@(posedge mclk) disable iff (!por_n)
      $fell(opfail_reg) |-> $rose(start_reg) && op_reg == 4'h0)
      else $error("fail flag cleared wrongly");

   a_opfail_set: assert property (@(posedge mclk) disable iff (!por_n)
      start_reg && flash_fail |=> opfail_reg)
      else $error("fail flag not set");

   a_lvfail_clear: assert property (@(posedge mclk) disable iff (!por_n)
      $fell(lvfail_reg) |-> $rose(start_reg) && op_reg == 4'h0)
      else $error("low voltage flag cleared wrongly");

   a_lvfail_set: assert property (@(posedge mclk) disable iff (!por_n)
      start_reg && flash_low_volt |=> lvfail_reg)
      else $error("low voltage flag not set");

   // Bank swap
   a_swap_guard: assert property (@(posedge mclk) disable iff (!nrst)
      $changed(swap_reg) |-> !$past(wen_reg) && $past(unlocked))
      else $error("swap changed without unlock");

   a_lower_bank_map: assert property (@(posedge mclk)
      lower_bank_is_2 == bank_swap)
      else $error("bank map differs from swap bit");

   // Power-on reset
   a_por_clears: assert property (@(posedge mclk)
      !$past(por_n) |-> !start_reg && !wen_reg && !opfail_reg && !lvfail_reg)
      else $error("power-on reset left a flag set");

   // Read view
   a_reserved_zero: assert property (@(posedge mclk) disable iff (!nrst)
      wb_ack_o |-> (rdat_reg & 32'hFFFF0F70) == 32'h0)
      else $error("reserved bits nonzero");

   a_rdat_idle_zero: assert property (@(posedge mclk) disable iff (!nrst)
      !wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data outside acknowledge");

   // Unlock sequence
   a_lock_one_shot: assert property (@(posedge mclk) disable iff (!nrst)
      unlocked && req |=> !unlocked)
      else $error("unlock outlived one access");

   a_unlock_order: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(unlocked) |-> $past(lock_reg == fpc_pkg::FPC_LK_KEY1))
      else $error("unlock without first key");

   a_unlock_full_word: assert property (@(posedge mclk)
      disable iff (!nrst)
      $rose(unlocked) |-> $past(wb_sel_i == 4'hF))
      else $error("unlock from partial key write");

   // Bus handshake
   a_ack_follows_req: assert property (@(posedge mclk) disable iff (!nrst)
      req |=> wb_ack_o)
      else $error("request not acknowledged");

   a_ack_one_cycle: assert property (@(posedge mclk) disable iff (!nrst)
      wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");

   a_ack_needs_req: assert property (@(posedge mclk) disable iff (!nrst)
      wb_ack_o |-> $past(req))
      else $error("acknowledge without request");

   // Interrupt status
   a_done_sets_stat: assert property (@(posedge mclk) disable iff (!nrst)
      start_reg && flash_done |=> stat_reg[fpc_pkg::IRQ_DONE])
      else $error("done status not set");

   a_fail_sets_stat: assert property (@(posedge mclk) disable iff (!nrst)
      start_reg && flash_fail |=> stat_reg[fpc_pkg::IRQ_OPFAIL])
      else $error("fail status not set");

   a_lv_sets_stat: assert property (@(posedge mclk) disable iff (!nrst)
      start_reg && flash_low_volt |=> stat_reg[fpc_pkg::IRQ_LVFAIL])
      else $error("low voltage status not set");
endmodule

// file: rtl/fpc_pkg.sv
package fpc_pkg;
   // Byte addresses on the Wishbone slave
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_KEY = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
   // Control register field positions
   localparam int BIT_START = 15;
   localparam int BIT_WEN = 14;
   localparam int BIT_OPFAIL = 13;
   localparam int BIT_LVFAIL = 12;
   localparam int BIT_SWAP = 7;
   localparam int OP_LSB = 0;
   localparam int OP_W = 4;
   localparam logic [3:0] OP_CLEAR_ERR = 4'h0;
   // Unlock keys, written in this order to the key register
   localparam logic [31:0] KEY_FIRST = 32'hAA996655;
   localparam logic [31:0] KEY_SECOND = 32'h556699AA;
   // Interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_OPFAIL = 1;
   localparam int IRQ_LVFAIL = 2;
   localparam int IRQ_W = 3;
   typedef enum logic [1:0] {
      FPC_LK_IDLE = 2'b00,
      FPC_LK_KEY1 = 2'b01,
      FPC_LK_OPEN = 2'b10
   } fpc_lock_t;
endpackage

// file: sim/fpc_flash_model.sv
module fpc_flash_model (
   input wire logic mclk,
   input wire logic flash_go,
   input wire logic [3:0] dly,
   input wire logic fail_cmd,
   input wire logic lv_cmd,
   output logic flash_done,
   output logic flash_fail,
   output logic flash_low_volt
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = -1;
   // Faults are shown one cycle before completion, while start is still set
   always @(posedge mclk) begin
      flash_done <= (cnt == 0);
      flash_fail <= (cnt == 1) && fail_cmd;
      flash_low_volt <= (cnt == 1) && lv_cmd;
      if (flash_go === 1'b1) begin
         cnt <= int'(dly);
      end else if (cnt >= 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// file: sim/tb_flash_program_control.sv
module tb_flash_program_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, nrst = 0, por_n = 0, cyc = 0, stb = 0, we = 0;
   logic fail_cmd = 0, lv_cmd = 0, ack, go, done, ff, flv, swp, lb2, irq;
   logic [3:0] adr = 4'h0, dly = 4'h1, fop, go_op, sel = 4'hF;
   logic [31:0] dat = 32'h0, q, d, wdo;
   int fails = 0, samples_checked = 0, seed = 31, gos = 0;
   localparam logic [3:0] CT = fpc_pkg::ADDR_CTRL;
   localparam logic [3:0] ST = fpc_pkg::ADDR_IRQ_STAT;
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) if (go === 1'b1) begin
      gos <= gos + 1;
      go_op <= fop;
   end
   fpc_flash_program_control i_fpc_flash_program_control (.mclk(mclk),
      .nrst(nrst), .por_n(por_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wdo), .wb_ack_o(ack), .flash_op(fop), .flash_go(go),
      .flash_done(done), .flash_fail(ff), .flash_low_volt(flv),
      .bank_swap(swp), .lower_bank_is_2(lb2), .irq(irq));
   fpc_flash_model i_fpc_flash_model (.mclk(mclk), .flash_go(go),
      .dly(dly), .fail_cmd(fail_cmd), .lv_cmd(lv_cmd), .flash_done(done),
      .flash_fail(ff), .flash_low_volt(flv));
   function automatic logic [31:0] cx(input logic s, e, f, l, w,
                                      input logic [3:0] op);
      return {16'h0, s, e, f, l, 4'h0, w, 3'h0, op};
   endfunction
   task report_and_stop;
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wb(input logic w, input logic [3:0] a, input logic [31:0] x);
      int n;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= x;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) fails++;
      q = wdo;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task unlock;
      wb(1, fpc_pkg::ADDR_KEY, fpc_pkg::KEY_FIRST);
      wb(1, fpc_pkg::ADDR_KEY, fpc_pkg::KEY_SECOND);
   endtask
   task launch(input logic [3:0] op, input logic f, l, input logic [3:0] t);
      int n;
      fail_cmd <= f;
      lv_cmd <= l;
      dly <= t;
      wb(1, CT, 32'h0);
      wb(1, CT, 32'h4000 | op);
      unlock;
      wb(1, CT, 32'hC000);
      n = 0;
      do begin
         wb(0, CT, 0);
         n++;
      end while (q[15] !== 1'b0 && n < 30);
      if (n >= 30) fails++;
   endtask
   initial begin
      repeat (5000) @(posedge mclk);
      fails++;
      report_and_stop;
   end
   initial begin
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      por_n <= 1'b1;
      wb(0, CT, 0);
      chk(q, 0);
      repeat (6) begin
         d = $random(seed) & 32'hFFFF3F7F;
         wb(1, CT, d);
         wb(0, CT, 0);
         chk(q, cx(0, 0, 0, 0, 0, d[3:0]));
      end
      // Low byte lane only: op code taken, enable untouched
      sel <= 4'h1;
      wb(1, CT, 32'h4005);
      sel <= 4'hF;
      wb(0, CT, 0);
      chk(q, cx(0, 0, 0, 0, 0, 4'h5));
      wb(0, 4'h2, 0);
      chk(q, 0);
      // Start refused without unlock, after a stray access, after part keys
      wb(1, CT, 32'h4009);
      wb(1, CT, 32'hC005);
      unlock;
      wb(0, CT, 0);
      wb(1, CT, 32'hC005);
      sel <= 4'h7;
      unlock;
      sel <= 4'hF;
      wb(1, CT, 32'hC005);
      wb(0, CT, 0);
      chk(q, cx(0, 1, 0, 0, 0, 4'h9));
      chk(gos, 0);
      // Slow engine that fails; software tries to clear start meanwhile
      fail_cmd <= 1'b1;
      dly <= 4'hF;
      unlock;
      wb(1, CT, 32'hC000);
      wb(0, CT, 0);
      chk(q[15], 1);
      wb(1, CT, 32'h4000);
      wb(0, CT, 0);
      chk(q[15], 1);
      chk(gos, 1);
      chk(go_op, 4'h9);
      repeat (20) @(posedge mclk);
      wb(0, CT, 0);
      chk(q, cx(0, 1, 1, 0, 0, 4'h9));
      wb(1, fpc_pkg::ADDR_IRQ_MASK, 0);
      wb(0, ST, 0);
      chk(q, 32'h3);
      chk(irq, 0);
      wb(1, fpc_pkg::ADDR_IRQ_MASK, 32'h2);
      wb(0, ST, 0);
      chk(irq, 1);
      wb(1, ST, 32'h2);
      wb(0, ST, 0);
      chk(q, 32'h1);
      chk(irq, 0);
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      wb(0, CT, 0);
      chk(q, cx(0, 1, 1, 0, 0, 4'h0));
      launch(4'h3, 0, 1, 4'h1);
      chk(q, cx(0, 1, 1, 1, 0, 4'h3));
      launch(4'h0, 0, 0, 4'h1);
      chk(q, cx(0, 1, 0, 0, 0, 4'h0));
      wb(1, CT, 0);
      unlock;
      wb(1, CT, 32'h80);
      wb(0, CT, 0);
      chk(q, 32'h80);
      chk(lb2, 1);
      wb(1, CT, 0);
      wb(0, CT, 0);
      chk(q, 32'h80); // locked again
      unlock;
      wb(1, CT, 0);
      chk({swp, lb2}, 0);
      report_and_stop;
   end
endmodule
